// >>> iso_rx_unpack_control.v
// Control, status and header capture of the isochronous receive unpacker
// Contract
// [RULE1] Read-only flag shows packet ready
// [RULE2] Enable sampled only at packet arrival
// [RULE3] Strip zero to three pad bytes
// [RULE4] Stamps processed only when enabled
// [RULE5] Reset bit holds receiver in reset
// [RULE6] Software holds reset one AV period
// [RULE7] Capture first header quadlet while running
// [RULE8] Top two bits are header marks
// [RULE9] Format value sits in bits 29..24
// [RULE10] FDF low, stamp in low sixteen
// [RULE11] Disable and drain before reset
// [RULE12] Software clears reset bit itself
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`include "iso_rx_consts.vh"
module iso_rx_unpack_control
(
   input  wire        sys_clk,
   input  wire        sys_rst,
   input  wire        clk_en,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        pkt_start,
   input  wire        hdr_one_valid,
   input  wire        hdr_two_valid,
   input  wire [31:0] hdr_quadlet,
   input  wire        data_valid,
   input  wire        data_last,
   input  wire [31:0] data_quadlet,
   input  wire        source_packet_pending,
   output reg         out_valid,
   output reg  [31:0] out_data,
   output reg  [3:0]  out_bytes,
   output reg         out_last,
   output reg         stamp_valid,
   output reg  [15:0] stamp_value,
   output reg         receiver_in_reset,
   output reg         irq
);

   ////////////////////////////////////////////////////////////////////////
   // Registers
   reg [31:0] control_reg;
   reg [31:0] header_one_reg;
   reg [31:0] header_two_reg;
   reg [`INT_WIDTH-1:0] int_status_reg;
   reg [`INT_WIDTH-1:0] int_mask_reg;
   reg        active_reg;
   reg        in_packet_reg;
   reg        ready_s1_reg;
   reg        ready_s2_reg;
   reg        ready_s3_reg;
   reg        ready_reg;

   wire       bus_setup;
   wire       access;
   wire       wr_access;
   wire       int_clear;
   wire       addr_ok;
   wire       rx_reset;
   wire       sync_en;
   wire [1:0] pad_count;
   wire [3:0] byte_valid;
   wire [`INT_WIDTH-1:0] int_event;
   reg  [31:0] read_mux;

   // Setup phase is the only cycle that launches an answer
   assign bus_setup = psel & ~penable;
   // Access completes on the edge where the registered pready is seen
   assign access = psel & penable & pready;
   assign wr_access = access & pwrite;
   assign int_clear = wr_access & (paddr == `OFS_INT_ACK);
   assign addr_ok = (paddr == `OFS_UNPACK_CONTROL) |
                    (paddr == `OFS_HEADER_ONE) |
                    (paddr == `OFS_HEADER_TWO) |
                    (paddr == `OFS_INT_ACK) |
                    (paddr == `OFS_INT_MASK);
   // [RULE5] Reset bit level
   assign rx_reset = control_reg[`BIT_RECEIVER_RESET];
   assign sync_en = control_reg[`BIT_SYNC_STAMP_EN];
   assign pad_count = control_reg[`BIT_PAD_HI:`BIT_PAD_LO];

   // [RULE3] Pad byte mask
   pad_strip u_pad
   (
      .pad_count    (pad_count),
      .last_quadlet (data_last),
      .byte_valid   (byte_valid)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pending flag from the buffer side, three-stage synchroniser
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ready_s1_reg <= 1'b0;
         ready_s2_reg <= 1'b0;
         ready_s3_reg <= 1'b0;
         ready_reg    <= 1'b0;
      end
      else if (clk_en)
      begin
         ready_s1_reg <= source_packet_pending;
         ready_s2_reg <= ready_s1_reg;
         ready_s3_reg <= ready_s2_reg;
         // [RULE1] Settled ready flag
         if (ready_s2_reg == ready_s3_reg)
            ready_reg <= ready_s3_reg & ~rx_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave, no wait states
   always @*
   begin
      read_mux = 32'h00000000;
      case (paddr)
         `OFS_UNPACK_CONTROL:
         begin
            read_mux = control_reg & `CTRL_WRITE_MASK;
            read_mux[`BIT_SOURCE_READY] = ready_reg;
         end
         `OFS_HEADER_ONE: read_mux = header_one_reg;
         `OFS_HEADER_TWO: read_mux = header_two_reg;
         `OFS_INT_ACK:    read_mux[`INT_WIDTH-1:0] = int_status_reg;
         `OFS_INT_MASK:   read_mux[`INT_WIDTH-1:0] = int_mask_reg;
         default:         read_mux = 32'h00000000;
      endcase
   end

   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else if (clk_en)
      begin
         pready  <= bus_setup;
         pslverr <= bus_setup & ~addr_ok;
         if (bus_setup & ~pwrite)
            prdata <= read_mux;
         else if (~psel)
            prdata <= 32'h00000000;
      end
   end

   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         control_reg  <= `CTRL_RESET_VALUE;
         int_mask_reg <= {`INT_WIDTH{1'b0}};
      end
      else if (clk_en & wr_access)
      begin
         if (paddr == `OFS_UNPACK_CONTROL)
            control_reg <= pwdata & `CTRL_WRITE_MASK;
         if (paddr == `OFS_INT_MASK)
            int_mask_reg <= pwdata[`INT_WIDTH-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive path
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         active_reg        <= 1'b0;
         in_packet_reg     <= 1'b0;
         header_one_reg    <= 32'h00000000;
         header_two_reg    <= 32'h00000000;
         out_valid         <= 1'b0;
         out_data          <= 32'h00000000;
         out_bytes         <= 4'h0;
         out_last          <= 1'b0;
         stamp_valid       <= 1'b0;
         stamp_value       <= 16'h0000;
         receiver_in_reset <= 1'b1;
      end
      else if (clk_en)
      begin
         receiver_in_reset <= rx_reset;
         out_valid   <= 1'b0;
         out_last    <= 1'b0;
         stamp_valid <= 1'b0;
         if (rx_reset)
         begin
            // [RULE5] Hold receiver idle
            active_reg    <= 1'b0;
            in_packet_reg <= 1'b0;
            out_bytes     <= 4'h0;
         end
         else
         begin
            if (pkt_start)
            begin
               // [RULE2] Enable sampled here
               active_reg    <= control_reg[`BIT_RECEIVER_EN];
               in_packet_reg <= control_reg[`BIT_RECEIVER_EN];
            end
            // [RULE7] Capture first header
            if (active_reg & hdr_one_valid)
               header_one_reg <= hdr_quadlet;
            if (active_reg & hdr_two_valid)
            begin
               // [RULE8] Marks, format, FDF
               header_two_reg <= hdr_quadlet;
               // [RULE4] Stamp only when enabled
               if (sync_en)
               begin
                  // [RULE10] Low sixteen bits
                  stamp_valid <= 1'b1;
                  stamp_value <= hdr_quadlet[`STAMP_WIDTH-1:0];
               end
            end
            if (active_reg & in_packet_reg & data_valid)
            begin
               out_valid <= 1'b1;
               out_data  <= data_quadlet;
               // [RULE3] Apply pad mask
               out_bytes <= byte_valid;
               out_last  <= data_last;
               if (data_last)
                  in_packet_reg <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts: set wins over write-one clear
   assign int_event[`INT_PACKET_DONE] = active_reg & in_packet_reg &
                                        data_valid & data_last & ~rx_reset;
   // [RULE8] Marks checked against expected
   assign int_event[`INT_HEADER_BAD] = active_reg & hdr_two_valid &
      ~rx_reset & (hdr_quadlet[31:30] != `HQ2_MARK_EXPECTED);

   // One sticky status bit per event source
   genvar g;
   generate
      for (g = 0; g < `INT_WIDTH; g = g + 1)
      begin : g_int
         always @(posedge sys_clk)
         begin
            if (sys_rst)
               int_status_reg[g] <= 1'b0;
            else if (clk_en)
            begin
               // Set wins so an event in the clear cycle is not lost
               if (int_event[g])
                  int_status_reg[g] <= 1'b1;
               else if (int_clear & pwdata[g])
                  int_status_reg[g] <= 1'b0;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Level interrupt, registered so the pin comes from a flip-flop
   always @(posedge sys_clk)
   begin
      if (sys_rst)
         irq <= 1'b0;
      else if (clk_en)
         irq <= |(int_status_reg & int_mask_reg);
   end
endmodule

// >>> iso_rx_consts.vh
// Register map and field positions of the isochronous receive unpacker
`ifndef ISO_RX_CONSTS_VH
`define ISO_RX_CONSTS_VH
`define OFS_UNPACK_CONTROL  12'h040
`define OFS_HEADER_ONE      12'h044
`define OFS_HEADER_TWO      12'h048
`define OFS_INT_ACK         12'h04C
`define OFS_INT_MASK        12'h050
`define BIT_RECEIVER_RESET  0
`define BIT_SYNC_STAMP_EN   1
`define BIT_PAD_LO          2
`define BIT_PAD_HI          3
`define BIT_RECEIVER_EN     4
`define BIT_SOURCE_READY    5
`define CTRL_RESET_VALUE    32'h00000000
`define CTRL_WRITE_MASK     32'h0000001F
`define INT_PACKET_DONE     0
`define INT_HEADER_BAD      1
`define INT_WIDTH           2
`define HQ2_MARK_EXPECTED   2'h2
`define STAMP_WIDTH         16
`endif

// >>> pad_strip.v
// Byte enable mask for the last quadlet after pad stripping
`timescale 1ns/10ps
module pad_strip
(
   input  wire [1:0] pad_count,
   input  wire       last_quadlet,
   output reg  [3:0] byte_valid
);
   always @*
   begin
      byte_valid = 4'hF;
      if (last_quadlet)
      begin
         case (pad_count)
            2'h0:    byte_valid = 4'hF;
            2'h1:    byte_valid = 4'hE;
            2'h2:    byte_valid = 4'hC;
            2'h3:    byte_valid = 4'h8;
            default: byte_valid = 4'hF;
         endcase
      end
   end
endmodule

// >>> iso_rx_chk.sv
// Port assertions for the receive unpacker control block
`timescale 1ns/10ps
module iso_rx_chk
(
   input wire        sys_clk,
   input wire        sys_rst,
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire        pslverr,
   input wire        hdr_two_valid,
   input wire [31:0] hdr_quadlet,
   input wire        data_valid,
   input wire        data_last,
   input wire [31:0] data_quadlet,
   input wire        out_valid,
   input wire [31:0] out_data,
   input wire [3:0]  out_bytes,
   input wire        out_last,
   input wire        stamp_valid,
   input wire [15:0] stamp_value,
   input wire        receiver_in_reset
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than a cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_reset_quiet: assert property
      (receiver_in_reset |-> !out_valid && !stamp_valid)
      else $error("output while receiver in reset");
   a_data_forward: assert property (out_valid |-> $past(data_valid)
      && out_data == $past(data_quadlet) && out_last == $past(data_last))
      else $error("forwarded quadlet differs");
   a_full_bytes: assert property
      (out_valid && !out_last |-> out_bytes == 4'hF)
      else $error("inner quadlet not whole");
   a_last_msb: assert property (out_last |-> out_valid && out_bytes[3])
      else $error("last quadlet lost its first byte");
   a_stamp_src: assert property (stamp_valid |-> $past(hdr_two_valid)
      && stamp_value == $past(hdr_quadlet[15:0]))
      else $error("stamp not from second header");
endmodule
bind iso_rx_unpack_control iso_rx_chk u_chk (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .hdr_two_valid(hdr_two_valid),
   .hdr_quadlet(hdr_quadlet), .data_valid(data_valid),
   .data_last(data_last), .data_quadlet(data_quadlet),
   .out_valid(out_valid), .out_data(out_data), .out_bytes(out_bytes),
   .out_last(out_last), .stamp_valid(stamp_valid),
   .stamp_value(stamp_value), .receiver_in_reset(receiver_in_reset));

// >>> phy_model.sv
// Bus-side packet source; released lines show inverted data
`timescale 1ns/10ps
module phy_model
(
   input  wire        sys_clk,
   output reg         ps,
   output reg         h1v,
   output reg         h2v,
   output reg  [31:0] hq,
   output reg         dv,
   output reg         dl,
   output reg  [31:0] dq
);
   initial
   begin
      {ps, h1v, h2v, dv, dl} = 5'h00;
      hq = 32'h0;
      dq = 32'h0;
   end
   task send(input [31:0] h1, input [31:0] h2, input integer n);
      integer i;
   begin
      ps <= 1'b1;
      @(posedge sys_clk);
      ps <= 1'b0;
      h1v <= 1'b1;
      hq <= h1;
      @(posedge sys_clk);
      h1v <= 1'b0;
      h2v <= 1'b1;
      hq <= h2;
      for (i = 0; i < n; i = i + 1)
      begin
         @(posedge sys_clk);
         h2v <= 1'b0;
         hq <= ~h2;
         dv <= 1'b1;
         dl <= (i == n - 1);
         dq <= h1 ^ i;
      end
      @(posedge sys_clk);
      {dv, dl} <= 2'h0;
      dq <= ~dq;
      @(posedge sys_clk);
   end
   endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the receive unpacker control block
`timescale 1ns/10ps
module testbench;
   reg         sys_clk, sys_rst, psel, penable, pwrite, pend, err;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd, h1m, h2m, a;
   wire [31:0] prdata, hq, dq, od;
   wire [3:0]  ob;
   wire [15:0] sv;
   wire        pready, pslverr, ps, h1v, h2v, dv, dl, ov, ol, svd, rir, irq;
   integer     fail_count, comparisons, seed, ctl, st, p;
   reg  [36:0] exp_q[$];
   reg  [15:0] stp_q[$];
   phy_model phy (.sys_clk(sys_clk), .ps(ps), .h1v(h1v), .h2v(h2v),
      .hq(hq), .dv(dv), .dl(dl), .dq(dq));
   iso_rx_unpack_control uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pkt_start(ps), .hdr_one_valid(h1v),
      .hdr_two_valid(h2v), .hdr_quadlet(hq), .data_valid(dv),
      .data_last(dl), .data_quadlet(dq), .source_packet_pending(pend),
      .out_valid(ov), .out_data(od), .out_bytes(ob), .out_last(ol),
      .stamp_valid(svd), .stamp_value(sv), .receiver_in_reset(rir),
      .irq(irq));
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task chk(input [39:0] e, input [39:0] g, input string nm);
   begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
         fail_count = fail_count + 1;
         $display("unexpected %0s: expected %h seen %h", nm, e, g);
      end
   end
   endtask
   task end_of_test;
   begin
      $display("errors %0d checks %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask
   task apb(input w, input [11:0] ad, input [31:0] d);
      integer n;
   begin
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 20)
      begin
         n = n + 1;
         @(posedge sys_clk);
      end
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
      @(posedge sys_clk);
      if (n == 20)
      begin
         chk(1, 0, "pready");
         end_of_test;
      end
   end
   endtask
   task wctl(input [31:0] v);
   begin
      ctl = v & 32'h1F;
      apb(1, 12'h040, v | ($random(seed) & 32'hFFFFFFE0));
   end
   endtask
   task pkt(input [31:0] b, input integer n);
      integer k;
   begin
      a = $random(seed);
      if (ctl[4] && !ctl[0])
      begin
         {h1m, h2m} = {a, b};
         st = st | 1 | ((b[31:30] != 2'h2) << 1);
         if (ctl[1])
            stp_q.push_back(b[15:0]);
         for (k = 0; k < n; k = k + 1)
            exp_q.push_back({k == n - 1,
               k == n - 1 ? 4'hF << ctl[3:2] : 4'hF, a ^ k});
      end
      phy.send(a, b, n);
   end
   endtask
   always @(posedge sys_clk)
   begin
      if (ov === 1'b1)
         chk(exp_q.size() ? exp_q.pop_front() : 0, {ol, ob, od}, "out");
      if (svd === 1'b1)
         chk(stp_q.size() ? stp_q.pop_front() : 17'h10000, sv, "stamp");
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      chk(0, 1, "timeout");
      end_of_test;
   end
   initial
   begin
      {psel, penable, pwrite, pend, sys_rst} = 5'h01;
      {paddr, pwdata, h1m, h2m} = 0;
      {fail_count, comparisons, ctl, st} = 0;
      seed = 87393;
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      apb(0, 12'h040, 0);
      chk(32'h0, rd, "ctl");
      chk(0, rir, "rir");
      apb(1, 12'h054, 32'hFFFFFFFF);
      apb(0, 12'h054, 0);
      chk({1'b1, 32'h0}, {err, rd}, "unmapped");
      for (p = 0; p < 4; p = p + 1)
      begin
         wctl(32'h10 | (p << 2) | ((p & 1) << 1));
         pkt({p == 3 ? 2'h1 : 2'h2, 30'h0} | ($random(seed) >> 2), p + 1);
         apb(1, 12'h044, 32'h0);
         apb(0, 12'h044, 0);
         chk(h1m, rd, "hdr1");
         apb(0, 12'h048, 0);
         chk(h2m, rd, "hdr2");
      end
      apb(0, 12'h04C, 0);
      chk(st, rd, "status");
      apb(1, 12'h050, 1);
      repeat (2) @(posedge sys_clk);
      chk(1, irq, "irq");
      apb(1, 12'h04C, 3);
      repeat (2) @(posedge sys_clk);
      chk(0, irq, "irq");
      fork
         pkt(32'h80000001, 6);
         begin
            repeat (4) @(posedge sys_clk);
            // disable first, keep pad and stamp settings
            wctl(32'h0E);
         end
      join
      pkt(32'h80000002, 2);
      apb(0, 12'h044, 0);
      chk(h1m, rd, "hdr1");
      pend <= 1'b1;
      repeat (8) @(posedge sys_clk);
      apb(0, 12'h040, 0);
      chk(32'h20 | ctl, rd, "ready");
      wctl(32'h11);
      repeat (2) @(posedge sys_clk);
      chk(1, rir, "rst");
      pkt(32'h80000003, 2);
      apb(0, 12'h040, 0);
      chk(32'h11, rd, "ctl");
      wctl(32'h0);
      repeat (4) @(posedge sys_clk);
      chk(0, {rir, exp_q.size()}, "drain");
      end_of_test;
   end
endmodule
